// File: common/wdog_pkg.sv
// Package: register map, field layout, reset values and types of the watchdog
package wdog_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RANGE_OFFSET = 8'h04;
    localparam logic [7:0] COUNT_OFFSET = 8'h08;
    localparam logic [7:0] RESTART_OFFSET = 8'h0c;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] INTCLR_OFFSET = 8'h14;
    // Control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_PULSE_LSB = 2;
    localparam int CTRL_SPARE_BIT = 5;
    // Timeout range field positions
    localparam int RANGE_REG_LSB = 0;
    localparam int RANGE_INIT_LSB = 4;
    // Spare bit reset value and restart code
    localparam logic CTRL_SPARE_RESET = 1'b0;
    localparam logic [7:0] RESTART_CODE = 8'h76;
    // Fixed period base exponent: code i gives 2^(FIXED_BASE_EXP+i) clocks
    localparam int FIXED_BASE_EXP = 16;
    // Extra cycles in separate timer clock mode: sync plus clock availability
    localparam int SYNC_DELAY_CYCLES = 2;
    localparam int CLOCK_AVAIL_CYCLES = 2;

    // Bus request from the APB host
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } apb_req_s;

    // Timer event outputs
    typedef struct packed {
        logic irq;
        logic sys_rst;
    } wdog_out_s;
endpackage

// File: logic/pulse_stretch.sv
// Module: stretches a one-cycle trigger into a reset pulse of coded length
`timescale 1ns/100ps
module pulse_stretch
    import wdog_pkg::*;
#(
    parameter int EXTRA_CYCLES = 0
)
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic trigger_i,
    input wire logic [2:0] length_code_i,
    output logic active_o
);
    logic [8:0] count_ff;
    logic [8:0] nxt_count;
    logic [8:0] length;

    // Code to cycle count; codes 1/2 and 6/7 intentionally alias
    always_comb
    begin
        unique case (length_code_i)
            3'h0: length = 9'h002;
            3'h1: length = 9'h004;
            3'h2: length = 9'h004;
            3'h3: length = 9'h010;
            3'h4: length = 9'h020;
            3'h5: length = 9'h040;
            3'h6: length = 9'h080;
            3'h7: length = 9'h080;
        endcase
        nxt_count = count_ff;
        if (trigger_i)
            nxt_count = length + 9'(EXTRA_CYCLES);
        else if (count_ff != 9'h000)
            nxt_count = count_ff - 9'h001;
    end

    // Counter register; output is high while cycles remain
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
            count_ff <= 9'h000;
        else
            count_ff <= nxt_count;
    end

    assign active_o = (count_ff != 9'h000);
endmodule

// File: logic/wdog_timer.sv
// Module: watchdog control, timeout range and current count over APB
`timescale 1ns/100ps
// Operation
// - Control bits 31:6 read zero, ignore writes
// - Control bit 5 plain spare storage bit
// - Pulse field sets reset length in cycles
// - Hardcoded pulse length makes field read-only
// - Separate clock mode adds sync delay
// - Mode bit: reset, or interrupt then reset
// - Hardcoded mode makes mode bit read-only
// - Enable writable only when not always-enabled
// - Disabled: counter holds, no interrupt, reset
// - Enable, once set, cleared only by reset
// - Initial period used at first restart
// - Initial field locked if hardcoded or always-on
// - Later restarts use the regular period
// - Oversized fixed periods saturate to counter maximum
// - Fixed period code i is 2^(16+i)
// - Initial field exists only with dual periods
// - Regular period applies at next restart
// - Hardcoded period makes field read-only
// - Count register read coherently, live value
// - Count register read-only, zero above width
// - Restart code reloads counter when enabled, clears interrupt
module wdog_timer
    import wdog_pkg::*;
#(
    parameter int CNT_WIDTH = 32,
    parameter bit ALWAYS_ENABLED = 1'b0,
    parameter bit PULSE_LENGTH_HARDCODED = 1'b0,
    parameter bit RESPONSE_MODE_HARDCODED = 1'b0,
    parameter bit PERIOD_HARDCODED = 1'b0,
    parameter bit DUAL_PERIOD = 1'b1,
    parameter bit USE_FIXED_PERIOD = 1'b1,
    parameter bit SEPARATE_TIMER_CLOCK = 1'b0,
    parameter logic [2:0] DEFAULT_PULSE_LENGTH = 3'h0,
    parameter logic DEFAULT_RESPONSE_MODE = 1'b0,
    parameter logic [3:0] DEFAULT_PERIOD = 4'h0,
    parameter logic [3:0] DEFAULT_INITIAL_PERIOD = 4'h0,
    parameter logic [31:0] COUNTER_RESET_VALUE = 32'hffffffff,
    parameter logic [511:0] USER_PERIODS = {16{32'h0000ffff}},
    parameter logic [511:0] USER_INIT_PERIODS = {16{32'h0000ffff}}
)
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire wdog_pkg::apb_req_s APB_REQ_I,
    input wire logic TIMER_TICK_I,
    output logic [31:0] APB_RDATA_O,
    output logic APB_READY_O,
    output logic APB_SLVERR_O,
    output wdog_pkg::wdog_out_s WDOG_O
);
    import wdog_pkg::*;

    // Control and range fields
    logic enable_ff, nxt_enable;
    logic mode_ff, nxt_mode;
    logic spare_ff, nxt_spare;
    logic [2:0] pulse_ff, nxt_pulse;
    logic [3:0] period_ff, nxt_period;
    logic [3:0] init_ff, nxt_init;

    // Counter state and restart history
    logic kicked_ff, nxt_kicked;
    logic irq_ff, nxt_irq;
    logic [CNT_WIDTH-1:0] count_ff, nxt_count;

    // Bus answer registers
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff, nxt_ready;

    // Timer clock synchroniser: unstable, stable and previous copies
    logic tick_meta_ff, tick_sync_ff, tick_prev_ff;

    // Decoded strobes and timer events
    logic wr, rd, restart, intclr, tick, timeout, trig, rst_active;
    logic [CNT_WIDTH-1:0] reload;
    logic [3:0] sel_code;
    logic rst_ff;
    logic [31:0] count_word;

    // Period lookup: fixed power of two saturated to counter maximum, or user value
    // Limitation: user periods wider than the counter are cut, not refused
    function automatic logic [CNT_WIDTH-1:0] period_of(
        input logic [3:0] code, input logic initial_sel);
        logic [32:0] full;
        full = 33'h000000000;
        if (USE_FIXED_PERIOD)
        begin
            full = 33'h000000001 << (FIXED_BASE_EXP + int'(code));
            if (FIXED_BASE_EXP + int'(code) >= CNT_WIDTH)
                full = {33{1'b1}};
        end
        else if (initial_sel)
            full = {1'b0, USER_INIT_PERIODS[int'(code)*32 +: 32]};
        else
            full = {1'b0, USER_PERIODS[int'(code)*32 +: 32]};
        return full[CNT_WIDTH-1:0];
    endfunction

    // Access phase decode; ready_ff masks the cycle of the answer, so a
    // host still holding its access then is not taken a second time
    assign wr = APB_REQ_I.sel & APB_REQ_I.enable & APB_REQ_I.write & ~ready_ff;
    assign rd = APB_REQ_I.sel & APB_REQ_I.enable & ~APB_REQ_I.write
        & ~ready_ff;
    assign restart = wr && APB_REQ_I.addr == RESTART_OFFSET
        && APB_REQ_I.wdata[7:0] == RESTART_CODE;
    assign intclr = rd && APB_REQ_I.addr == INTCLR_OFFSET;
    // Tick edge from the timer clock; only synchronised copies are read
    assign tick = SEPARATE_TIMER_CLOCK ? (tick_sync_ff & ~tick_prev_ff)
        : 1'b1;
    // Timeout is judged on the tick, so a slow timer clock sets the pace
    assign timeout = enable_ff & tick
        & (count_ff == '0);
    // First restart uses the initial code, later ones the regular code
    assign sel_code = (DUAL_PERIOD && !kicked_ff) ? init_ff
        : period_ff;
    assign reload = period_of(sel_code, DUAL_PERIOD && !kicked_ff);
    // Reset on timeout in reset mode, or second timeout in interrupt mode
    assign trig = timeout & (~mode_ff | irq_ff);
    // Live count, zero-extended; one word read so it is always coherent
    assign count_word = 32'(count_ff);

    // Control and range register next values
    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_mode = mode_ff;
        nxt_spare = spare_ff;
        nxt_pulse = pulse_ff;
        nxt_period = period_ff;
        nxt_init = init_ff;
        if (wr && APB_REQ_I.addr == CTRL_OFFSET)
        begin
            // Bits 31:6 are never stored, so they always read zero
            nxt_spare = APB_REQ_I.wdata[CTRL_SPARE_BIT];
            if (!PULSE_LENGTH_HARDCODED)
                nxt_pulse = APB_REQ_I.wdata[CTRL_PULSE_LSB +: 3];
            if (!RESPONSE_MODE_HARDCODED)
                nxt_mode = APB_REQ_I.wdata[CTRL_MODE_BIT];
            // Sticky set: a zero write never clears it
            if (!ALWAYS_ENABLED && APB_REQ_I.wdata[CTRL_ENABLE_BIT])
                nxt_enable = 1'b1;
        end
        if (wr && APB_REQ_I.addr == RANGE_OFFSET && !PERIOD_HARDCODED)
        begin
            nxt_period = APB_REQ_I.wdata[RANGE_REG_LSB +: 4];
            if (DUAL_PERIOD && !ALWAYS_ENABLED)
                nxt_init = APB_REQ_I.wdata[RANGE_INIT_LSB +: 4];
        end
    end

    // Counter, restart tracking and interrupt next values
    always_comb
    begin
        nxt_count = count_ff;
        nxt_kicked = kicked_ff;
        nxt_irq = irq_ff;
        // A restart while disabled only clears the interrupt; count holds
        if (enable_ff)
        begin
            if (restart)
            begin
                nxt_count = reload;
                nxt_kicked = 1'b1;
            end
            else if (timeout)
                nxt_count = reload;
            else if (tick)
                nxt_count = count_ff - 1'b1;
        end
        // Clears first, so a timeout in the same cycle still sets the flag
        if (restart || intclr)
            nxt_irq = 1'b0;
        if (timeout && mode_ff && !irq_ff)
            nxt_irq = 1'b1;
        if (trig)
            nxt_irq = 1'b0;
    end

    // Read data and ready; one wait state, no error answers
    always_comb
    begin
        nxt_ready = rd | wr;
        nxt_rdata = 32'h00000000;
        if (rd)
        begin
            unique case (APB_REQ_I.addr)
                CTRL_OFFSET: nxt_rdata = {26'h0000000, spare_ff, pulse_ff,
                    mode_ff, enable_ff};
                RANGE_OFFSET: nxt_rdata = {24'h000000,
                    DUAL_PERIOD ? init_ff : 4'h0, period_ff};
                COUNT_OFFSET: nxt_rdata = count_word;
                STATUS_OFFSET: nxt_rdata = {31'h00000000, irq_ff};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            enable_ff <= ALWAYS_ENABLED;
            mode_ff <= DEFAULT_RESPONSE_MODE;
            spare_ff <= CTRL_SPARE_RESET;
            pulse_ff <= DEFAULT_PULSE_LENGTH;
            period_ff <= DEFAULT_PERIOD;
            init_ff <= DUAL_PERIOD ? DEFAULT_INITIAL_PERIOD : 4'h0;
            kicked_ff <= 1'b0;
            irq_ff <= 1'b0;
            count_ff <= COUNTER_RESET_VALUE[CNT_WIDTH-1:0];
            rdata_ff <= 32'h00000000;
            ready_ff <= 1'b0;
            tick_meta_ff <= 1'b0;
            tick_sync_ff <= 1'b0;
            tick_prev_ff <= 1'b0;
            rst_ff <= 1'b0;
        end
        else
        begin
            enable_ff <= nxt_enable;
            mode_ff <= nxt_mode;
            spare_ff <= nxt_spare;
            pulse_ff <= nxt_pulse;
            period_ff <= nxt_period;
            init_ff <= nxt_init;
            kicked_ff <= nxt_kicked;
            irq_ff <= nxt_irq;
            count_ff <= nxt_count;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            tick_meta_ff <= TIMER_TICK_I;
            tick_sync_ff <= tick_meta_ff;
            tick_prev_ff <= tick_sync_ff;
            rst_ff <= rst_active;
        end
    end

    // Reset pulse generator; extra cycles only in separate clock mode
    // Limitation: the length code is taken only when a pulse starts
    pulse_stretch #(
        .EXTRA_CYCLES(SEPARATE_TIMER_CLOCK
            ? SYNC_DELAY_CYCLES + CLOCK_AVAIL_CYCLES : 0)
    ) u_pulse (
        .CLOCK_I(CLOCK_I),
        .RESET_I(RESET_I),
        .trigger_i(trig),
        .length_code_i(pulse_ff),
        .active_o(rst_active)
    );

    // Outputs straight from registers; no error answer is ever given
    assign APB_RDATA_O = rdata_ff;
    assign APB_READY_O = ready_ff;
    assign APB_SLVERR_O = 1'b0;
    assign WDOG_O.irq = irq_ff;
    assign WDOG_O.sys_rst = rst_ff;
endmodule

// File: verification/wdog_timer_chk.sv
// Checker: handshake, reserved bits and watchdog outputs
`timescale 1ns/100ps
module wdog_timer_chk
    import wdog_pkg::*;
#(
    parameter int CNT_WIDTH = 32
)
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire wdog_pkg::apb_req_s APB_REQ_I,
    input wire logic [31:0] APB_RDATA_O,
    input wire logic APB_READY_O,
    input wire wdog_pkg::wdog_out_s WDOG_O
);
    logic tk;
    logic rdn;
    logic en_seen_ff;
    logic nxt_en_seen;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);
    // Accepted access phase, and a finished read
    assign tk = APB_REQ_I.sel && APB_REQ_I.enable && !APB_READY_O;
    assign rdn = APB_READY_O && !APB_REQ_I.write;
    // Enable is sticky, so one write of bit 0 arms the check for good
    always_comb
    begin
        nxt_en_seen = en_seen_ff;
        if (tk && APB_REQ_I.write && APB_REQ_I.addr == CTRL_OFFSET)
            nxt_en_seen = en_seen_ff | APB_REQ_I.wdata[CTRL_ENABLE_BIT];
    end
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
            en_seen_ff <= 1'b0;
        else
            en_seen_ff <= nxt_en_seen;
    end
    AST_READY_ONE: assert property
        (tk |=> APB_READY_O)
        else $error("ready missing after access");
    AST_READY_PULSE: assert property
        (APB_READY_O |=> !APB_READY_O)
        else $error("ready longer than one cycle");
    AST_IDLE_QUIET: assert property
        (!(APB_REQ_I.sel && APB_REQ_I.enable) |=> !APB_READY_O)
        else $error("ready without access");
    AST_CTRL_RSVD: assert property
        (rdn && APB_REQ_I.addr == CTRL_OFFSET
        |-> APB_RDATA_O[31:6] == 26'h0)
        else $error("control upper bits not zero");
    AST_COUNT_RSVD: assert property
        (rdn && APB_REQ_I.addr == COUNT_OFFSET
        |-> (APB_RDATA_O >> CNT_WIDTH) == 32'h0)
        else $error("count bits above width not zero");
    AST_EN_STICKY: assert property
        (rdn && APB_REQ_I.addr == CTRL_OFFSET && en_seen_ff
        |-> APB_RDATA_O[0])
        else $error("enable bit cleared");
    AST_DISABLED_QUIET: assert property
        (!en_seen_ff |-> !WDOG_O.irq && !WDOG_O.sys_rst)
        else $error("output while disabled");
    AST_RST_MIN: assert property
        ($rose(WDOG_O.sys_rst) |=> WDOG_O.sys_rst)
        else $error("reset pulse shorter than two cycles");
    AST_KICK_CLEARS: assert property (tk && APB_REQ_I.write &&
        APB_REQ_I.addr == RESTART_OFFSET && APB_REQ_I.wdata[7:0] == RESTART_CODE
        |-> ##[1:2] !WDOG_O.irq)
        else $error("restart left interrupt set");
    COV_IRQ: cover property ($rose(WDOG_O.irq));
    COV_RST: cover property ($rose(WDOG_O.sys_rst));
    COV_CNT: cover property (rdn && APB_REQ_I.addr == COUNT_OFFSET);
endmodule
bind wdog_timer wdog_timer_chk #(.CNT_WIDTH(CNT_WIDTH)) chk_u (
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .APB_REQ_I(APB_REQ_I),
    .APB_RDATA_O(APB_RDATA_O), .APB_READY_O(APB_READY_O), .WDOG_O(WDOG_O));

// File: verification/apb_host_model.sv
// Host model: APB master running one transfer per call
`timescale 1ns/100ps
module apb_host_model
    import wdog_pkg::*;
(
    input wire logic clk_i,
    input wire logic ready_i,
    input wire logic [31:0] rdata_i,
    output wdog_pkg::apb_req_s req_o
);
    initial
    begin
        req_o = '0;
    end
    // Access held until ready is sampled or 8 cycles pass; released lines show inverted junk
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output bit ok);
        ok = 1'b0;
        r = 32'h0;
        @(posedge clk_i);
        #1;
        req_o = '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        req_o.enable = 1'b1;
        for (int i = 0; i < 8 && !ok; i++)
        begin
            @(posedge clk_i);
            ok = (ready_i === 1'b1);
            r = rdata_i;
        end
        #1;
        req_o = '{sel: 1'b0, enable: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask
endmodule

// File: verification/wdog_timer_test.sv
// Testbench: registers, timeouts and reset pulses of the watchdog
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
module wdog_timer_test;
    import wdog_pkg::*;
    localparam logic [31:0] INIT_P = 32'h14;
    localparam logic [31:0] REG_P = 32'hc8;
    int n_fail = 0;
    int n_compared = 0;
    int len;
    int plen[8] = '{2, 4, 4, 16, 32, 64, 128, 128};
    logic clk;
    logic rst = 1'b1;
    logic ready;
    logic slverr;
    logic [31:0] r;
    logic [31:0] r2;
    apb_req_s req;
    wdog_out_s wout;
    apb_host_model host_u (.clk_i(clk), .ready_i(ready), .rdata_i(r2),
        .req_o(req));
    // Small periods keep the run short; initial and regular differ
    wdog_timer #(.CNT_WIDTH(16), .USE_FIXED_PERIOD(1'b0),
        .COUNTER_RESET_VALUE(32'h31234), .USER_PERIODS({16{REG_P}}),
        .USER_INIT_PERIODS({16{INIT_P}})) dut_u (.CLOCK_I(clk),
        .RESET_I(rst), .APB_REQ_I(req), .TIMER_TICK_I(1'b0),
        .APB_RDATA_O(r2), .APB_READY_O(ready), .APB_SLVERR_O(slverr),
        .WDOG_O(wout));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang();
        n_fail++;
        $display("[FAIL] %0t wait ran out", $time);
        close_out();
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        bit ok;
        host_u.xfer(w, a, d, r, ok);
        if (!ok)
            hang();
    endtask
    // Waits for a watchdog output, then counts the high cycles of the reset output only
    task automatic wait_out(input bit pulse);
        int i;
        for (i = 0; i < 400; i++)
        begin
            @(posedge clk);
            if ((pulse ? wout.sys_rst : wout.irq) === 1'b1)
                break;
        end
        if (i == 400)
            hang();
        len = 0;
        do
        begin
            len++;
            @(posedge clk);
        end while (pulse && wout.sys_rst === 1'b1 && len < 300);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        acc(0, CTRL_OFFSET, 0); `CHK(r, 32'h0)
        acc(0, RANGE_OFFSET, 0); `CHK(r, 32'h0)
        acc(0, 8'h20, 0); `CHK(r, 32'h0)
        `CHK(slverr, 1'b0)
        acc(1, CTRL_OFFSET, 32'hfffffffe);
        acc(0, CTRL_OFFSET, 0); `CHK(r, 32'h3e)
        acc(1, CTRL_OFFSET, 0);
        acc(0, CTRL_OFFSET, 0); `CHK(r, 32'h0)
        acc(1, RANGE_OFFSET, 32'hffffffa5);
        acc(0, RANGE_OFFSET, 0); `CHK(r, 32'ha5)
        acc(0, COUNT_OFFSET, 0); `CHK(r, 32'h1234)
        $display("register fields done");
        acc(1, CTRL_OFFSET, 1);
        acc(1, RESTART_OFFSET, RESTART_CODE);
        acc(0, COUNT_OFFSET, 0); `CHK(r <= INIT_P, 1'b1)
        acc(1, CTRL_OFFSET, 0);
        acc(0, CTRL_OFFSET, 0); `CHK(r[0], 1'b1)
        acc(1, RESTART_OFFSET, RESTART_CODE);
        acc(0, COUNT_OFFSET, 0);
        `CHK(r > INIT_P && r <= REG_P, 1'b1)
        len = r;
        acc(1, RESTART_OFFSET, 32'h75);
        acc(0, COUNT_OFFSET, 0); `CHK(r < len, 1'b1)
        $display("restart periods done");
        for (int c = 0; c < 8; c++)
        begin
            acc(1, CTRL_OFFSET, c * 4 + 1);
            acc(1, RESTART_OFFSET, RESTART_CODE);
            wait_out(1);
            `CHK(len, plen[c])
        end
        $display("pulse lengths done");
        acc(1, CTRL_OFFSET, 3);
        acc(1, RESTART_OFFSET, RESTART_CODE);
        wait_out(0); `CHK(wout.sys_rst, 1'b0)
        acc(0, STATUS_OFFSET, 0); `CHK(r, 32'h1)
        acc(0, INTCLR_OFFSET, 0);
        acc(0, STATUS_OFFSET, 0); `CHK(r, 32'h0)
        acc(1, RESTART_OFFSET, RESTART_CODE);
        @(posedge clk);
        #1;
        `CHK(wout.irq, 1'b0)
        wait_out(0);
        wait_out(1); `CHK(len, 2)
        $display("interrupt mode done");
        // Mid-run reset: only a system reset may drop the enable bit
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        acc(0, CTRL_OFFSET, 0); `CHK(r, 32'h0)
        acc(0, COUNT_OFFSET, 0); `CHK(r, 32'h1234)
        `CHK(wout, 2'b00)
        $display("mid-run reset done");
        close_out();
    end
endmodule
